// ---- src/config_wakeup_sequencer.sv ----
/*
  post-configuration wake-up sequencer: steps phases T0..T3 and drives
  the completion pin and the global output enable, write disable and
  set/reset controls; also makes the master configuration clock.
  assumes all strap and setting inputs are static during configuration.
*/
`timescale 1ns/1ns
module config_wakeup_sequencer
  import wakeup_pkg::*;
#(
  parameter int unsigned FREQ_WIDTH = DIV_WIDTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // configuration engine status
  input wire logic config_done_bit,
  input wire logic config_error,
  input wire logic config_start,
  input wire logic freq_field_valid,
  input wire logic [FREQ_WIDTH-1:0] master_clock_freq_select,
  // settings
  input wire logic wait_external_complete,
  input wire logic complete_pin_open_drain,
  input wire logic overflow_enable,
  input wire logic [4:0] wake_sequence,
  input wire logic keep_config_port,
  input wire logic readback_lock,
  input wire logic jtag_port,
  input wire logic readback_request,
  input wire logic readback_id_area,
  // straps and completion pin
  input wire logic [1:0] port_select,
  input wire logic complete_pin_in,
  output logic complete_pin_out,
  output logic complete_pin_oe_n,
  // global controls
  output logic global_output_enable,
  output logic global_write_disable,
  output logic global_set_reset,
  // config port and clock
  output logic [1:0] active_port,
  output logic config_port_active,
  output logic config_clock,
  output logic config_clock_oe_n,
  output logic startup_from_test_clock,
  output logic readback_grant,
  output logic readback_refused
);

  initial begin
    if (FREQ_WIDTH < 2) $error("config_wakeup_sequencer: FREQ_WIDTH small");
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence table lookup

  function automatic phase_map_t seq_map(input logic [4:0] s);
    phase_map_t m;
    m = '{PH_T3, PH_T1, PH_T2, PH_T2};
    case (s)
      5'h01: m = '{PH_T0, PH_T1, PH_T1, PH_T1};
      5'h02: m = '{PH_T0, PH_T2, PH_T2, PH_T2};
      5'h03: m = '{PH_T0, PH_T3, PH_T3, PH_T3};
      5'h04: m = '{PH_T0, PH_T1, PH_T2, PH_T2};
      5'h05: m = '{PH_T0, PH_T1, PH_T3, PH_T3};
      5'h06: m = '{PH_T0, PH_T1, PH_T2, PH_T3};
      5'h07: m = '{PH_T0, PH_T1, PH_T3, PH_T2};
      5'h08: m = '{PH_T1, PH_T2, PH_T2, PH_T2};
      5'h09: m = '{PH_T1, PH_T3, PH_T3, PH_T3};
      5'h0a: m = '{PH_T1, PH_T3, PH_T2, PH_T2};
      5'h0b: m = '{PH_T1, PH_T2, PH_T3, PH_T3};
      5'h0c: m = '{PH_T2, PH_T3, PH_T3, PH_T3};
      5'h0d: m = '{PH_T2, PH_T1, PH_T1, PH_T1};
      5'h0e: m = '{PH_T2, PH_T1, PH_T3, PH_T3};
      5'h0f: m = '{PH_T2, PH_T1, PH_T1, PH_T3};
      5'h10: m = '{PH_T2, PH_T3, PH_T1, PH_T3};
      5'h11: m = '{PH_T2, PH_T3, PH_T1, PH_T1};
      5'h12: m = '{PH_T2, PH_T1, PH_T3, PH_T1};
      5'h13: m = '{PH_T3, PH_T2, PH_T2, PH_T2};
      5'h14: m = '{PH_T3, PH_T1, PH_T1, PH_T1};
      5'h15: m = '{PH_T3, PH_T1, PH_T2, PH_T2};
      5'h16: m = '{PH_T3, PH_T1, PH_T1, PH_T2};
      5'h17: m = '{PH_T3, PH_T2, PH_T1, PH_T2};
      5'h18: m = '{PH_T3, PH_T2, PH_T1, PH_T1};
      5'h19: m = '{PH_T3, PH_T1, PH_T2, PH_T1};
      default: m = '{PH_T3, PH_T1, PH_T2, PH_T2};
    endcase
    return m;
  endfunction

  // control is on once the current phase reaches its phase
  function automatic logic reached(input logic [1:0] cur,
                                   input logic [1:0] at);
    return cur >= at;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three flops, change counts when 2nd and 3rd agree

  logic [2:0] pin_sync;
  logic pin_high;
  logic [2:0] sel0_sync;
  logic [2:0] sel1_sync;
  logic [1:0] port_latched;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_sync <= 3'h0;
      sel0_sync <= 3'h0;
      sel1_sync <= 3'h0;
      pin_high <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], complete_pin_in};
      sel0_sync <= {sel0_sync[1:0], port_select[0]};
      sel1_sync <= {sel1_sync[1:0], port_select[1]};
      if (pin_sync[1] == pin_sync[2]) pin_high <= pin_sync[2];
    end
  end

  // port select straps caught at configuration start
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      port_latched <= PORT_SLAVE_SERIAL;
    end else if (config_start && sel0_sync[1] == sel0_sync[2] &&
                 sel1_sync[1] == sel1_sync[2]) begin
      port_latched <= {sel1_sync[2], sel0_sync[2]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequence selection and wait mode

  wire seq_in_range = (wake_sequence >= SEQ_MIN) &&
    (wake_sequence <= (overflow_enable ? SEQ_MAX_OVERFLOW : SEQ_MAX));
  wire [4:0] eff_seq = seq_in_range ? wake_sequence :
    (overflow_enable ? SEQ_DEFAULT_OVERFLOW : SEQ_DEFAULT);
  wire eff_wait = wait_external_complete | overflow_enable;
  wire eff_open_drain = eff_wait | complete_pin_open_drain;
  wire phase_map_t map = seq_map(eff_seq);
  wire master_mode = (port_latched == PORT_MASTER_SERIAL);

  ////////////////////////////////////////////////////////////////////////
  // state machine

  wake_state_t state;
  wake_state_t next_state;
  logic [1:0] phase;
  logic [1:0] next_phase;
  logic done_before_ext;

  // start decisions for the two wake-up processes
  wire int_start = config_done_bit && !config_error && !eff_wait;
  wire ext_start = pin_high && eff_wait;

  always_comb begin
    next_state = state;
    next_phase = phase;
    case (state)
      ST_CONFIG: begin
        if (config_error) begin
          next_state = ST_ERROR;
        end else if (int_start) begin
          next_state = ST_RUN;
          next_phase = PH_T0;
        end else if (config_done_bit) begin
          next_state = ST_WAIT_EXT;
        end
      end
      ST_WAIT_EXT: begin
        if (ext_start) begin
          next_state = ST_RUN;
          next_phase = PH_T0;
        end
      end
      ST_RUN: begin
        if (phase == PH_T3) next_state = ST_USER;
        else next_phase = phase + 2'h1;
      end
      ST_USER: next_state = ST_USER;
      ST_ERROR: next_state = ST_ERROR;
      default: next_state = ST_CONFIG;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= ST_CONFIG;
      phase <= PH_T0;
    end else begin
      state <= next_state;
      phase <= next_phase;
    end
  end

  // in waiting mode the pin is released when the bit sets, so that
  // the shared net can go high once every chained device lets go
  assign done_before_ext = (state == ST_WAIT_EXT);

  ////////////////////////////////////////////////////////////////////////
  // control outputs, held on once reached

  wire running = (state == ST_RUN);
  wire in_user = (state == ST_USER);
  // once let go the pin stays released, so chained devices filtering
  // the shared net never see it fall again during the run
  wire next_done = complete_pin_out || in_user || done_before_ext ||
    (running && reached(phase, map.done_ph));
  wire next_oe = in_user || (running && reached(phase, map.oe_ph));
  wire next_wd = in_user || (running && reached(phase, map.wd_ph));
  wire next_sr = in_user || (running && reached(phase, map.sr_ph));

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      complete_pin_out <= 1'b0;
      complete_pin_oe_n <= 1'b0;
      global_output_enable <= 1'b0;
      global_write_disable <= 1'b0;
      global_set_reset <= 1'b0;
    end else begin
      // low is always driven; high is released or driven per mode
      complete_pin_out <= next_done;
      complete_pin_oe_n <= next_done && eff_open_drain;
      global_output_enable <= next_oe;
      global_write_disable <= next_wd;
      global_set_reset <= next_sr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration port, clock source and readback

  wire port_on = !in_user || keep_config_port;
  wire rb_ok = port_on && (!readback_lock || readback_id_area);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      active_port <= PORT_SLAVE_SERIAL;
      config_port_active <= 1'b1;
      config_clock_oe_n <= 1'b1;
      startup_from_test_clock <= 1'b0;
      readback_grant <= 1'b0;
      readback_refused <= 1'b0;
    end else begin
      active_port <= port_latched;
      config_port_active <= port_on;
      config_clock_oe_n <= !master_mode;
      startup_from_test_clock <= jtag_port;
      readback_grant <= readback_request && rb_ok;
      readback_refused <= readback_request && !rb_ok;
    end
  end

  wire clk_run = master_mode && (state == ST_CONFIG || port_on);

  master_clock_gen #(.WIDTH(FREQ_WIDTH)) u_clk (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(clk_run),
    .load(freq_field_valid),
    .half_period(master_clock_freq_select),
    .clk_out(config_clock)
  );

endmodule

// ---- src/master_clock_gen.sv ----
/*
  master configuration clock generator with a glitchless rate switch.
  assumes the half period setting is stable while load is low.
*/
`timescale 1ns/1ns
module master_clock_gen
  import wakeup_pkg::*;
#(
  parameter int unsigned WIDTH = DIV_WIDTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  input wire logic load,
  input wire logic [WIDTH-1:0] half_period,
  // clock out
  output logic clk_out
);

  initial begin
    if (WIDTH < $clog2(DEFAULT_HALF_CYCLES + 1))
      $error("master_clock_gen: WIDTH too small");
  end

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] active_half;
  logic [WIDTH-1:0] pending_half;
  logic pending;

  // new rate only takes effect at a falling edge, so no short pulse
  wire at_edge = (count + 1'b1 >= active_half);
  wire falling = at_edge && clk_out;
  wire [WIDTH-1:0] safe_half = (half_period == '0) ? WIDTH'(1) : half_period;

  // divider and rate switch
  always_ff @(posedge mclk) begin
    if (!rst_n || !enable) begin
      count <= '0;
      clk_out <= 1'b0;
      active_half <= WIDTH'(DEFAULT_HALF_CYCLES);
      pending <= 1'b0;
      pending_half <= WIDTH'(DEFAULT_HALF_CYCLES);
    end else begin
      if (load) begin
        pending <= 1'b1;
        pending_half <= safe_half;
      end
      if (at_edge) begin
        count <= '0;
        clk_out <= ~clk_out;
        if (falling && pending && !load) begin
          active_half <= pending_half;
          pending <= 1'b0;
        end
      end else begin
        count <= count + 1'b1;
      end
    end
  end

endmodule

// ---- src/wakeup_pkg.sv ----
/*
  shared constants and types for the configuration wake-up sequencer.
  assumes a single 100 MHz system clock, mclk.
*/
package wakeup_pkg;

  // number of wake-up phases and sequence limits
  localparam int unsigned NUM_PHASES = 4;
  localparam logic [4:0] SEQ_MIN = 5'h01;
  localparam logic [4:0] SEQ_MAX = 5'h19;
  localparam logic [4:0] SEQ_MAX_OVERFLOW = 5'h07;
  localparam logic [4:0] SEQ_DEFAULT = 5'h15;
  localparam logic [4:0] SEQ_DEFAULT_OVERFLOW = 5'h04;

  // phase codes: 0..3 for T0..T3
  localparam logic [1:0] PH_T0 = 2'h0;
  localparam logic [1:0] PH_T1 = 2'h1;
  localparam logic [1:0] PH_T2 = 2'h2;
  localparam logic [1:0] PH_T3 = 2'h3;

  // configuration port select codes
  localparam logic [1:0] PORT_SLAVE_SERIAL = 2'h0;
  localparam logic [1:0] PORT_MASTER_SERIAL = 2'h1;
  localparam logic [1:0] PORT_SLAVE_PARALLEL = 2'h2;
  localparam logic [1:0] PORT_SELF_DOWNLOAD = 2'h3;

  // master clock timing
  localparam int unsigned MCLK_HZ = 100_000_000;
  localparam int unsigned MASTER_CLK_DEFAULT_HZ = 2_500_000;
  localparam int unsigned DEFAULT_HALF_CYCLES =
    MCLK_HZ / (2 * MASTER_CLK_DEFAULT_HZ);
  localparam int unsigned DIV_WIDTH = 8;
  localparam logic [DIV_WIDTH-1:0] DEFAULT_HALF =
    DIV_WIDTH'(DEFAULT_HALF_CYCLES);

  // phase at which each control goes active for one sequence
  typedef struct packed {
    logic [1:0] done_ph;
    logic [1:0] oe_ph;
    logic [1:0] wd_ph;
    logic [1:0] sr_ph;
  } phase_map_t;

  // the set of global controls driven by the sequencer
  typedef struct packed {
    logic complete;
    logic output_enable;
    logic write_disable;
    logic set_reset;
  } wake_ctrl_t;

  typedef enum logic [2:0] {
    ST_CONFIG = 3'b000,
    ST_WAIT_EXT = 3'b001,
    ST_RUN = 3'b010,
    ST_USER = 3'b011,
    ST_ERROR = 3'b100
  } wake_state_t;

endpackage

// ---- verification/config_wakeup_sequencer_assertions.sv ----
/*
  port checker for the wake-up sequencer.
  assumes settings only change while reset is held.
*/
`timescale 1ns/1ns
module wakeup_checker
  import wakeup_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // settings and requests
  input wire logic config_done_bit,
  input wire logic config_error,
  input wire logic wait_external_complete,
  input wire logic overflow_enable,
  input wire logic [4:0] wake_sequence,
  input wire logic jtag_port,
  input wire logic readback_request,
  input wire logic readback_lock,
  input wire logic readback_id_area,
  input wire logic complete_pin_in,
  // watched outputs
  input wire logic complete_pin_out,
  input wire logic complete_pin_oe_n,
  input wire logic global_output_enable,
  input wire logic global_write_disable,
  input wire logic global_set_reset,
  input wire logic [1:0] active_port,
  input wire logic config_clock_oe_n,
  input wire logic startup_from_test_clock,
  input wire logic readback_refused
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // pin let go by the device
  wire logic rel = complete_pin_oe_n | complete_pin_out;
  //////////////////////////////////////////////////////////////////
  // phase steps
  sequence s_oe_up; $rose(global_output_enable); endsequence
  sequence s_ws_up;
    $rose(global_write_disable) && $rose(global_set_reset);
  endsequence
  property p_oe_hold; global_output_enable |=> global_output_enable;
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("output enable dropped");
  property p_sr_rep; $rose(global_set_reset) |=> global_set_reset[*4];
  endproperty
  a_sr_rep: assert property (p_sr_rep)
    else $error("set reset dropped");
  property p_pin_done; !config_done_bit |-> !rel; endproperty
  a_pin_done: assert property (p_pin_done)
    else $error("pin let go before completion");
  property p_od_forced;
    (wait_external_complete || overflow_enable) && complete_pin_out
      |-> complete_pin_oe_n;
  endproperty
  a_od_forced: assert property (p_od_forced)
    else $error("pin not open drain while waiting");
  property p_wait_pin;
    wait_external_complete && $rose(global_output_enable)
      |-> $past(complete_pin_in, 3);
  endproperty
  a_wait_pin: assert property (p_wait_pin)
    else $error("wake-up before pin high");
  property p_span;
    s_oe_up |-> ##[0:3] (global_write_disable && global_set_reset);
  endproperty
  a_span: assert property (p_span)
    else $error("controls spread beyond four phases");
  property p_seq21;
    (!wait_external_complete && !overflow_enable &&
      wake_sequence == 5'h15) ##0 s_oe_up |=> s_ws_up ##1 $rose(rel);
  endproperty
  a_seq21: assert property (p_seq21)
    else $error("default sequence order wrong");
  property p_seq4;
    (overflow_enable && wake_sequence == 5'h04) ##0 s_oe_up |=> s_ws_up;
  endproperty
  a_seq4: assert property (p_seq4)
    else $error("overflow sequence order wrong");
  property p_clk_oe;
    !config_clock_oe_n |-> active_port == PORT_MASTER_SERIAL;
  endproperty
  a_clk_oe: assert property (p_clk_oe)
    else $error("clock driven outside master mode");
  property p_test_clk; jtag_port |=> startup_from_test_clock; endproperty
  a_test_clk: assert property (p_test_clk)
    else $error("startup clock source wrong");
  property p_readback;
    readback_request && readback_lock && !readback_id_area
      |=> readback_refused;
  endproperty
  a_readback: assert property (p_readback)
    else $error("locked readback not refused");
  property p_done_hold; complete_pin_out |=> complete_pin_out;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("completion pin pulled low again");
  property p_int_wake;
    $rose(config_done_bit) && !config_error && !wait_external_complete &&
      !overflow_enable |-> ##5 (global_output_enable &&
      global_write_disable && global_set_reset);
  endproperty
  a_int_wake: assert property (p_int_wake)
    else $error("wake-up did not follow completion bit");
  property p_ovf_wait;
    overflow_enable && $rose(config_done_bit) |-> ##5 !global_output_enable;
  endproperty
  a_ovf_wait: assert property (p_ovf_wait)
    else $error("overflow did not hold off wake-up");
endmodule

bind config_wakeup_sequencer wakeup_checker i_chk (.*);

// ---- verification/config_wakeup_sequencer_tb_top.sv ----
/*
  self-checking bench for the wake-up sequencer.
  assumes the peer model and checker are compiled first.
*/
`timescale 1ns/1ns
module config_wakeup_sequencer_tb_top;
  import wakeup_pkg::*;
  logic mclk = 0, rst_n = 0, config_done_bit = 0, config_error = 0;
  logic config_start = 0, freq_field_valid = 0, rel = 1;
  logic [7:0] master_clock_freq_select = 8'h05;
  logic wait_external_complete = 0, complete_pin_open_drain = 1;
  logic overflow_enable = 0, keep_config_port = 0, readback_lock = 0;
  logic jtag_port = 0, readback_request = 0, readback_id_area = 0;
  logic [4:0] wake_sequence = 5'h15;
  logic [1:0] port_select = 2'h0, active_port;
  logic complete_pin_out, complete_pin_oe_n, global_output_enable;
  logic global_write_disable, global_set_reset, config_port_active;
  logic config_clock, config_clock_oe_n, startup_from_test_clock;
  logic readback_grant, readback_refused, peer_oe_n;
  int fails = 0, total_checks = 0, cyc = 0, n, i;
  // phase maps of sequences 1..25: done, oe, wd, sr
  phase_map_t maps [25] = '{8'h15, 8'h2a, 8'h3f, 8'h1a, 8'h1f, 8'h1b,
    8'h1e, 8'h6a, 8'h7f, 8'h7a, 8'h6f, 8'hbf, 8'h95, 8'h9f, 8'h97,
    8'hb7, 8'hb5, 8'h9d, 8'hea, 8'hd5, 8'hda, 8'hd6, 8'he6, 8'he5, 8'hd9};
  // wired completion net with pull-up
  wire complete_pin_in = peer_oe_n & (complete_pin_oe_n | complete_pin_out);
  config_wakeup_sequencer i_dut (.*);
  done_peer_model i_peer (.mclk(mclk), .rst_n(rst_n), .release_req(rel),
    .drive_oe_n(peer_oe_n));
  //////////////////////////////////////////////////////////////////
  always #5 mclk = ~mclk;
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      summarize();
    end
  end
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // one wake-up; records the cycle each control first rises
  task automatic wake(input logic [4:0] s, input phase_map_t m,
                      input logic o, input logic e, input logic d);
    int r [4];
    int k, j, f;
    logic w;
    logic [3:0] v;
    w = o | e;
    f = w ? 2 : 3;
    r = '{-1, -1, -1, -1};
    rst_n = 0;
    wake_sequence = s;
    overflow_enable = o;
    wait_external_complete = e;
    complete_pin_open_drain = d;
    keep_config_port = s[1];
    config_done_bit = 0;
    rel = !w;
    repeat (2) tick();
    rst_n = 1;
    tick();
    config_done_bit = 1;
    for (k = 0; k < 22; k++) begin
      tick();
      if (k == 6) rel = 1;
      v = {complete_pin_oe_n | complete_pin_out, global_output_enable,
           global_write_disable, global_set_reset};
      for (j = 0; j < 4; j++) if (v[j] === 1'b1 && r[j] < 0) r[j] = k;
      if (k == 6 && w) check(v[2:0], 0);
      if (k > 0 && w) check(v[3], 1);
    end
    check(v, 4'hf);
    for (j = 0; j < 4 - w; j++)
      if (j != f)
        check(r[j] - r[f], int'(m[2*j+:2]) - int'(m[2*f+:2]));
    if (w) check(complete_pin_oe_n, 1);
    check(config_port_active, s[1]);
    check(config_clock_oe_n, 1);
    $display("wake sequence %0d done", s);
  endtask
  // count mclk edges in one whole half period of the master clock
  task automatic half(output int c);
    logic l;
    l = config_clock;
    while (config_clock === l && cyc < 4000) tick();
    l = config_clock;
    c = 0;
    while (config_clock === l && c < 99) begin
      tick();
      c++;
    end
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) tick();
    for (i = 0; i < 25; i++) wake(5'(i + 1), maps[i], 0, 0, i[0]);
    wake(5'h00, 8'hda, 0, 0, 1);
    wake(5'h09, 8'h1a, 1, 0, 0);
    wake(5'h04, 8'h1a, 1, 1, 1);
    wake(5'h15, 8'hda, 0, 1, 0);
    // error during configuration keeps the pin, output enable and set/reset held
    rst_n = 0;
    wait_external_complete = 0;
    overflow_enable = 0;
    config_error = 1;
    config_done_bit = 0;
    repeat (2) tick();
    rst_n = 1;
    tick();
    config_done_bit = 1;
    repeat (10) tick();
    check({complete_pin_oe_n | complete_pin_out, global_output_enable,
           global_set_reset}, 0);
    config_error = 0;
    $display("error test done");
    // master clock, port latch, startup source, readback lock
    rst_n = 0;
    config_done_bit = 0;
    port_select = 2'h1;
    config_start = 1;
    jtag_port = 1;
    repeat (2) tick();
    rst_n = 1;
    half(n);
    check(n, DEFAULT_HALF_CYCLES);
    check(config_clock_oe_n, 0);
    check(active_port, PORT_MASTER_SERIAL);
    check(startup_from_test_clock, 1);
    freq_field_valid = 1;
    tick();
    freq_field_valid = 0;
    half(n);
    half(n);
    check(n, 5);
    readback_lock = 1;
    readback_request = 1;
    tick();
    check(readback_refused, 1);
    readback_id_area = 1;
    tick();
    check(readback_grant, 1);
    readback_request = 0;
    $display("clock test done");
    summarize();
  end
endmodule

// ---- verification/done_peer_model.sv ----
/*
  other chained device sharing the completion net, open-drain.
  assumes the bench wires the net with a pull-up.
*/
`timescale 1ns/1ns
module done_peer_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // bench control
  input wire logic release_req,
  // open-drain pull, low while pulling the net down
  output logic drive_oe_n
);
  //////////////////////////////////////////////////////////////////
  // hold the net low, let go only on a clock edge
  always_ff @(posedge mclk) begin
    drive_oe_n <= rst_n & release_req;
  end
endmodule
